// *** hpw_pkg.sv ***
// What this block does
// - Mode input picks multiplexed or indexed addressing
// - Width 8 or 16; assemble into dwords
// - Separate strobes or enable plus direction
// - Every control line polarity is configurable
// - FIFO select routes writes to TX FIFO
// - Indexed mode ignores both address latches
// - Single phase 16 pins or dual 8
// - Single phase captures all on low latch
// - Upper pins never driven in 8-bit
// - Optional chip select qualification of latches
// - Latched address held until reset or relatch
// - Dual phase: low then high, any order
// - Dual phase upper pins data only
// - 8-bit single phase: address bit n on pin n
// - 16-bit: word address converted to bytes
// - Endian one above, FIFO two above address
// - Write trailing edge places byte, swaps endian
// - Writes ignored after init until a read
// - Writes ignored in low power until read
// - Count parts, then one 32-bit write
// - Part counter cleared outside full power
// - Endian zero little, one big
// - Internal bus 32-bit little endian
package hpw_pkg;
  // Address and dword geometry
  localparam int ADDR_W = 10;
  localparam int DW_W = 32;
  // Single phase pin positions, 8-bit width
  localparam int S8_END = 10;
  localparam int S8_FIFO = 11;
  // Single phase pin positions, 16-bit width
  localparam int S16_END = 9;
  localparam int S16_FIFO = 10;
  // Dual phase high latch positions, 8-bit width
  localparam int D8_END = 2;
  localparam int D8_FIFO = 3;
  // Dual phase high latch positions, 16-bit width
  localparam int D16_END = 1;
  localparam int D16_FIFO = 2;
  // Parts per dword
  localparam logic [2:0] PARTS_8 = 3'h4;
  localparam logic [2:0] PARTS_16 = 3'h2;
  // Reset values
  localparam logic [9:0] ADDR_RST = 10'h000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
endpackage : hpw_pkg

// *** hpw_edge.sv ***
`timescale 1ns/1ns
`default_nettype none
// Synchroniser with polarity and edge detection
module hpw_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins and polarity
  input wire logic [W-1:0] pin,
  input wire logic [W-1:0] act_high,
  // Active level and trailing edge
  output logic [W-1:0] level,
  output logic [W-1:0] fall
);
  // Two stage synchroniser plus history
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // sync stages hold the active level, idle at reset
  // Idle after reset avoids a false trailing edge on active-low pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      // polarity applied before the first stage
      s1 <= ~(pin ^ act_high);
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Active level and its trailing edge
  assign level = s2;
  assign fall = s3 & ~s2;
endmodule : hpw_edge
`default_nettype wire

// *** hpw_port.sv ***
`timescale 1ns/1ns
`default_nettype none
// Multiplexed host port: address latch and write assembly
module hpw_port (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Static configuration
  input wire logic cfg_muxed,
  input wire logic cfg_wide,
  input wire logic cfg_enb_mode,
  input wire logic cfg_dual_phase,
  input wire logic cfg_cs_qualify,
  input wire logic pol_cs,
  input wire logic pol_rd,
  input wire logic pol_wr,
  input wire logic pol_ale,
  // Host pins
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe,
  input wire logic cs_pin,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic low_addr_latch,
  input wire logic high_addr_latch,
  // Device state
  input wire logic full_power_state,
  input wire logic init_done,
  // Internal write port
  output logic [9:0] wr_addr,
  output logic [31:0] wr_data,
  output logic wr_fifo,
  output logic wr_reg,
  output logic wr_txfifo,
  // Status
  output logic [9:0] cur_addr,
  output logic cur_endian,
  output logic cur_fifo,
  output logic write_enabled,
  output logic [2:0] part_count
);
  // Synchronised strobes: cs, rd, wr, low_addr_latch, high_addr_latch
  logic [4:0] lvl;
  logic [4:0] fal;
  logic [15:0] ad_s1;
  logic [15:0] ad_s2;
  logic [15:0] ad_hold;
  logic rd_act;
  logic wr_act;
  logic rd_end;
  logic wr_end;
  logic wr_cyc_d;
  logic rd_cyc_d;
  logic lo_take;
  logic hi_take;
  logic [2:0] parts;
  logic [1:0] lane;
  logic [31:0] next_data;
  logic [2:0] next_count;

  hpw_edge #(.W(5)) u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .pin({high_addr_latch, low_addr_latch, wr_pin, rd_pin, cs_pin}),
    .act_high({pol_ale, pol_ale, pol_wr, pol_rd, pol_cs}),
    .level(lvl),
    .fall()
  );

  // Data pins sampled alongside strobes, held one extra cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ad_s1 <= '0;
      ad_s2 <= '0;
      ad_hold <= '0;
    end else begin
      ad_s1 <= ad_in;
      ad_s2 <= ad_s1;
      ad_hold <= ad_s2;
    end
  end

  // device never drives the pins here (no read path)
  assign ad_out = '0;
  assign ad_oe = '0;

  // decode cycle type from strobes or enable plus direction
  always_comb begin
    if (cfg_enb_mode) begin
      wr_act = lvl[2] && !lvl[1];
      rd_act = lvl[2] && lvl[1];
    end else begin
      wr_act = lvl[0] && lvl[2];
      rd_act = lvl[0] && lvl[1];
    end
  end

  // Cycle history for trailing edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_cyc_d <= 1'b0;
      rd_cyc_d <= 1'b0;
    end else begin
      wr_cyc_d <= wr_act;
      rd_cyc_d <= rd_act;
    end
  end
  // trailing edge of write or read cycle
  assign wr_end = wr_cyc_d && !wr_act;
  assign rd_end = rd_cyc_d && !rd_act;

  // latch edges, optionally qualified by chip select
  logic lo_d;
  logic hi_d;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_d <= 1'b0;
      hi_d <= 1'b0;
    end else begin
      lo_d <= lvl[3] && (lvl[0] || !cfg_cs_qualify);
      hi_d <= lvl[4] && (lvl[0] || !cfg_cs_qualify);
    end
  end
  assign lo_take = cfg_muxed && lo_d && !lvl[3];
  assign hi_take = cfg_muxed && hi_d && !lvl[4] && cfg_dual_phase;

  // address, endian and FIFO select held until relatch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_addr <= hpw_pkg::ADDR_RST;
      cur_endian <= 1'b0;
      cur_fifo <= 1'b0;
    end else begin
      if (lo_take && !cfg_dual_phase) begin
        if (cfg_wide) begin
          cur_addr <= {ad_hold[8:0], 1'b0};
          cur_endian <= ad_hold[hpw_pkg::S16_END];
          cur_fifo <= ad_hold[hpw_pkg::S16_FIFO];
        end else begin
          cur_addr <= ad_hold[9:0];
          cur_endian <= ad_hold[hpw_pkg::S8_END];
          cur_fifo <= ad_hold[hpw_pkg::S8_FIFO];
        end
      end else begin
        if (lo_take) begin
          if (cfg_wide)
            cur_addr[8:1] <= ad_hold[7:0];
          else
            cur_addr[7:0] <= ad_hold[7:0];
        end
        if (hi_take) begin
          if (cfg_wide) begin
            cur_addr[9] <= ad_hold[0];
            cur_addr[0] <= 1'b0;
            cur_endian <= ad_hold[hpw_pkg::D16_END];
            cur_fifo <= ad_hold[hpw_pkg::D16_FIFO];
          end else begin
            cur_addr[9:8] <= ad_hold[1:0];
            cur_endian <= ad_hold[hpw_pkg::D8_END];
            cur_fifo <= ad_hold[hpw_pkg::D8_FIFO];
          end
        end
      end
    end
  end

  // write gate: closed at reset, in low power; opened by read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_enabled <= 1'b0;
    end else if (!full_power_state || !init_done) begin
      write_enabled <= 1'b0;
    end else if (rd_end) begin
      write_enabled <= 1'b1;
    end
  end

  assign parts = cfg_wide ? hpw_pkg::PARTS_16 : hpw_pkg::PARTS_8;

  always_comb begin
    lane = cur_addr[1:0];
    if (cur_endian)
      lane = cfg_wide ? {~cur_addr[1], 1'b0} : ~cur_addr[1:0];
  end

  always_comb begin
    next_data = wr_data;
    if (cfg_wide) begin
      if (lane[1])
        next_data[31:16] = cur_endian ? {ad_hold[7:0], ad_hold[15:8]}
                                      : ad_hold;
      else
        next_data[15:0] = cur_endian ? {ad_hold[7:0], ad_hold[15:8]}
                                     : ad_hold;
    end else begin
      next_data[8*lane +: 8] = ad_hold[7:0];
    end
  end

  // part counter increments at each write trailing edge while the write gate is open
  always_comb begin
    next_count = part_count + 3'h1;
  end

  // Data register and counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_data <= hpw_pkg::DATA_RST;
      part_count <= 3'h0;
    end else if (!full_power_state) begin
      part_count <= 3'h0;
    end else if (wr_end && write_enabled) begin
      // host writes each part once; no check here
      wr_data <= next_data;
      part_count <= (next_count == parts) ? 3'h0 : next_count;
    end
  end

  // single internal write strobe on last part
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_fifo <= 1'b0;
      wr_reg <= 1'b0;
      wr_addr <= hpw_pkg::ADDR_RST;
      wr_txfifo <= 1'b0;
    end else begin
      wr_fifo <= 1'b0;
      wr_reg <= 1'b0;
      if (full_power_state && wr_end && write_enabled
          && next_count == parts) begin
        // FIFO select steers to TX data FIFO
        wr_fifo <= cur_fifo;
        wr_reg <= !cur_fifo;
        wr_addr <= {cur_addr[9:2], 2'b00};
      end
      wr_txfifo <= cur_fifo;
    end
  end
  // indexed burst mode lives in the indexed front end
endmodule : hpw_port
`default_nettype wire

// *** hpw_port_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
// Port-level checks for the host write port
module hpw_port_props (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs seen
  input wire logic cfg_wide,
  input wire logic full_power_state,
  // Outputs watched
  input wire logic [15:0] ad_oe,
  input wire logic [31:0] wr_data,
  input wire logic wr_reg,
  input wire logic wr_fifo,
  input wire logic cur_fifo,
  input wire logic write_enabled,
  input wire logic [2:0] part_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Parts in one dword
  logic [2:0] parts;
  assign parts = cfg_wide ? hpw_pkg::PARTS_16 : hpw_pkg::PARTS_8;
  chk_pins_quiet:
    assert property (ad_oe == 16'h0) else $error("pins driven");
  chk_fifo_route:
    assert property (wr_reg || wr_fifo |-> wr_fifo == cur_fifo)
    else $error("wrong target");
  chk_gate_holds:
    assert property (!write_enabled |=> part_count == $past(part_count))
    else $error("count moved while closed");
  chk_sleep_clears:
    assert property (!full_power_state |=>
      part_count == 3'h0 && !write_enabled) else $error("sleep kept count");
  chk_count_range:
    assert property (part_count < parts) else $error("count overrun");
  chk_commit_last:
    assert property (wr_reg || wr_fifo |-> $past(part_count) == parts - 3'h1)
    else $error("early commit");
  chk_data_commit:
    assert property ($changed(wr_data) |->
      part_count != $past(part_count) || wr_reg || wr_fifo)
    else $error("data moved alone");
  chk_pulse_once:
    assert property (wr_reg |=> !wr_reg) else $error("long pulse");
  // Main scenarios reached
  cover property (wr_reg);
  cover property ($rose(write_enabled));
  cover property (!full_power_state ##1 part_count == 3'h0);
endmodule : hpw_port_props
bind hpw_port hpw_port_props chk_u (.clk(clk), .arst_n(arst_n),
  .cfg_wide(cfg_wide), .full_power_state(full_power_state),
  .ad_oe(ad_oe), .wr_data(wr_data), .wr_reg(wr_reg), .wr_fifo(wr_fifo),
  .cur_fifo(cur_fifo), .write_enabled(write_enabled),
  .part_count(part_count));
`default_nettype wire

// *** hpw_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host processor model, levels active high
module hpw_host (
  // Clock
  input wire logic clk,
  // Host pins
  output logic [15:0] ad,
  output logic cs,
  output logic rd,
  output logic wr,
  output logic lo,
  output logic hi
);
  // Idle at time zero
  initial begin
    {ad, cs, rd, wr, lo, hi} = 21'h0;
  end
  // Cycle kinds: 0 low latch, 1 high latch, 2 write, 3 read, 4 enable read
  // one part per strobe
  task automatic cyc(input int k, input logic [15:0] d, input logic c);
    @(negedge clk);
    ad = d;
    cs = c;
    lo = (k == 0);
    hi = (k == 1);
    wr = (k == 2) || (k == 4);
    rd = (k == 3) || (k == 4);
    repeat (4) @(negedge clk);
    {cs, rd, wr, lo, hi} = 5'h0;
    repeat (2) @(negedge clk);
    // Released bus keeps the old value two cycles, then takes its inverse
    ad = ~d;
    repeat (5) @(negedge clk);
  endtask : cyc
endmodule : hpw_host
`default_nettype wire

// *** hpw_port_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the host write port
module hpw_port_tb;
  // Clock, reset, configuration
  logic clk;
  logic arst_n;
  logic wide, cycle_enable, dual, csq, pol, pwr, init, muxed;
  // Host levels before polarity
  logic [15:0] ad;
  logic h_cs, h_rd, h_wr, h_lo, h_hi;
  // Write side
  logic [9:0] wr_addr, cur_addr;
  logic [31:0] wr_data;
  logic wr_reg, wr_fifo, cur_fifo, endi, wen;
  logic [2:0] part_count;
  // Counters
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Commit pulses seen
  int n_reg = 0;
  int n_fifo = 0;
  hpw_host host_u (.clk(clk), .ad(ad), .cs(h_cs), .rd(h_rd), .wr(h_wr),
    .lo(h_lo), .hi(h_hi));
  hpw_port dut_u (.clk(clk), .arst_n(arst_n), .cfg_muxed(muxed),
    .cfg_wide(wide), .cfg_enb_mode(cycle_enable), .cfg_dual_phase(dual),
    .cfg_cs_qualify(csq), .pol_cs(pol), .pol_rd(pol), .pol_wr(pol),
    .pol_ale(pol), .ad_in(ad), .ad_out(), .ad_oe(), .cs_pin(h_cs ^ !pol),
    .rd_pin(h_rd ^ !pol), .wr_pin(h_wr ^ !pol),
    .low_addr_latch(h_lo ^ !pol), .high_addr_latch(h_hi ^ !pol),
    .full_power_state(pwr), .init_done(init), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_fifo(wr_fifo), .wr_reg(wr_reg), .wr_txfifo(),
    .cur_addr(cur_addr), .cur_endian(endi), .cur_fifo(cur_fifo),
    .write_enabled(wen), .part_count(part_count));
  // Count one-cycle commit pulses
  always @(posedge clk) begin
    if (wr_reg === 1'b1) n_reg++;
    if (wr_fifo === 1'b1) n_fifo++;
  end
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reset under a static configuration
  task automatic rst(input logic [3:0] c, input logic p);
    arst_n = 1'b0;
    {wide, cycle_enable, dual, csq} = c;
    pol = p;
    muxed = 1'b1;
    pwr = 1'b1;
    init = 1'b1;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
  endtask : rst
  // Latch an address then write one part
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    host_u.cyc(0, a, 1'b1);
    host_u.cyc(2, d, 1'b1);
  endtask : put
  // 8-bit single phase, bytes out of order
  task automatic t_bytes();
    rst(4'h0, 1'b1);
    put(16'h0004, 16'ha5ee);
    chk(32'(part_count), 32'h0);
    chk(32'(wen), 32'h0);
    host_u.cyc(3, 16'h0000, 1'b1);
    chk(32'(wen), 32'h1);
    put(16'h0007, 16'ha544);
    put(16'h0004, 16'h5a11);
    put(16'h0006, 16'hff33);
    chk(32'(part_count), 32'h3);
    put(16'h0005, 16'h0022);
    chk(wr_data, 32'h4433_2211);
    chk(32'(wr_addr[9:2]), 32'h1);
    chk(n_reg, 32'h1);
    $display("bytes done");
  endtask : t_bytes
  // 16-bit big endian, enable mode, inverted pins
  task automatic t_words();
    rst(4'hc, 1'b0);
    host_u.cyc(4, 16'h0000, 1'b1);
    put(16'h0202, 16'h1234);
    put(16'h0203, 16'h5678);
    chk(wr_data, 32'h3412_7856);
    chk(32'(wr_addr[9:2]), 32'h1);
    chk(32'(endi), 32'h1);
    chk(n_reg, 32'h2);
    $display("words done");
  endtask : t_words
  // Dual phase, select qualified, power drop
  task automatic t_dual();
    rst(4'h3, 1'b1);
    muxed = 1'b0;
    host_u.cyc(1, 16'h000a, 1'b1);
    chk(32'({cur_fifo, cur_addr}), 32'h0);
    muxed = 1'b1;
    host_u.cyc(1, 16'h000a, 1'b0);
    chk(32'({cur_fifo, cur_addr}), 32'h0);
    host_u.cyc(1, 16'h000a, 1'b1);
    host_u.cyc(0, 16'h000c, 1'b1);
    chk(32'({cur_fifo, cur_addr}), 32'h60c);
    host_u.cyc(3, 16'h0000, 1'b1);
    host_u.cyc(2, 16'h0055, 1'b1);
    chk(32'(part_count), 32'h1);
    pwr = 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(part_count), 32'h0);
    pwr = 1'b1;
    host_u.cyc(2, 16'h0055, 1'b1);
    chk(32'(part_count), 32'h0);
    chk(32'(cur_addr), 32'h20c);
    host_u.cyc(3, 16'h0000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      host_u.cyc(0, 16'(16'h000c + i), 1'b1);
      host_u.cyc(2, 16'(16'h00a0 + i), 1'b1);
    end
    chk(wr_data, 32'ha3a2_a1a0);
    chk(n_fifo, 32'h1);
    chk(n_reg, 32'h2);
    $display("dual done");
  endtask : t_dual
  // Verdict
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    t_bytes();
    t_words();
    t_dual();
    finish_test();
  end
endmodule : hpw_port_tb
`default_nettype wire
